// *** rtl/brownout_reset_mode_control.sv ***
// brown-out reset mode control and start/wake hold-off
`include "bor_ctrl_params.svh"
`default_nettype none
// What this block does
// - mode 11 keeps brown-out protection on in run and sleep
// - modes 11 and 10 hold start-up until detector ready and supply good
// - mode 11 keeps protection in sleep; wake does not wait on detector
// - mode 10 protects while running, never during sleep
// - mode 10 holds wake until detector ready and supply good
// - mode 01 protection follows the software enable bit
// - mode 01 skips start wait only if enable clear and no power/brown reset; skips wake wait if enable clear
// - mode 01 protects once ready; ready flag mirrors detector ready
// - mode 01 sleep does not change protection
// - mode 00 keeps protection off regardless of software enable
module brownout_reset_mode_control
   import bor_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // configuration and software control
   input wire logic [1:0] brownout_mode_select_in,
   input wire logic sw_brownout_enable_in,
   // detector
   input wire logic detector_ready_in,
   input wire logic supply_good_in,
   // core events
   input wire logic por_bor_start_in,
   input wire logic sleep_request_in,
   input wire logic wake_event_in,
   // status and outputs
   output logic brownout_ready_flag_out,
   output logic protection_active_out,
   output logic brownout_reset_out,
   output logic core_hold_out,
   output logic in_sleep_out
);

   bor_state_type state;
   bor_state_type next_state;
   logic por_start;

   wire mode_on = brownout_mode_select_in == `BOR_MODE_ON;
   wire mode_ns = brownout_mode_select_in == `BOR_MODE_NOSLEEP;
   wire mode_sw = brownout_mode_select_in == `BOR_MODE_SW;
   wire mode_off = brownout_mode_select_in == `BOR_MODE_OFF;
   // look at the coming state so mode 10 drops protection with in_sleep
   wire asleep = next_state == st_sleep;
   wire sw_prot = mode_sw && sw_brownout_enable_in
      && detector_ready_in;
   wire ready_good = detector_ready_in && supply_good_in;
   // protection per mode; mode 00 is never active
   wire next_prot = mode_on
      || (mode_ns && !asleep)
      || sw_prot;
   // start-up hold-off needed?
   wire start_wait = mode_on || mode_ns
      || (mode_sw && (sw_brownout_enable_in || por_start));
   // wake hold-off needed? always-on mode never waits
   wire wake_wait = mode_ns
      || (mode_sw && sw_brownout_enable_in);

   always_comb begin
      next_state = state;
      case (state)
         st_start: begin
            if (!start_wait || ready_good) begin
               next_state = st_run;
            end
         end
         st_run: begin
            if (sleep_request_in) begin
               next_state = st_sleep;
            end
         end
         st_sleep: begin
            if (wake_event_in) begin
               next_state = st_wake;
            end
         end
         st_wake: begin
            if (!wake_wait || ready_good) begin
               next_state = st_run;
            end
         end
         default: next_state = st_start;
      endcase
   end

   wire next_hold = next_state != st_run;
   wire next_bor = next_prot && !supply_good_in;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= st_start;
         por_start <= 1'b1;
      end else if (clk_en_in) begin
         state <= next_state;
         if (state == st_start && next_state == st_run) begin
            por_start <= 1'b0;
         end else if (por_bor_start_in) begin
            por_start <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         brownout_ready_flag_out <= 1'b0;
         protection_active_out <= 1'b0;
         brownout_reset_out <= 1'b0;
         core_hold_out <= 1'b1;
         in_sleep_out <= 1'b0;
      end else if (clk_en_in) begin
         brownout_ready_flag_out <= detector_ready_in;
         protection_active_out <= next_prot;
         brownout_reset_out <= next_bor;
         core_hold_out <= next_hold;
         in_sleep_out <= next_state == st_sleep;
      end
   end

   a_always_on_prot: assert property (@(posedge clk_in) disable iff (reset_in)
      !$past(reset_in) && $past(clk_en_in) && $past(mode_on)
      |-> protection_active_out)
      else $error("always-on mode lost protection");
   a_start_hold: assert property (@(posedge clk_in) disable iff (reset_in)
      (state == st_start) && (mode_on || mode_ns) && !ready_good && clk_en_in
      |=> core_hold_out)
      else $error("start-up released before detector ready");
   a_on_wake_fast: assert property (@(posedge clk_in) disable iff (reset_in)
      (state == st_wake) && mode_on && clk_en_in |=> !core_hold_out)
      else $error("always-on wake waited on detector");
   a_nosleep_off: assert property (@(posedge clk_in) disable iff (reset_in)
      mode_ns && next_state == st_sleep && clk_en_in
      |=> !protection_active_out)
      else $error("protection active in sleep in mode 10");
   a_ns_wake_hold: assert property (@(posedge clk_in) disable iff (reset_in)
      (state == st_wake) && mode_ns && !ready_good && clk_en_in
      |=> core_hold_out)
      else $error("mode 10 wake released early");
   a_sw_follows: assert property (@(posedge clk_in) disable iff (reset_in)
      mode_sw && clk_en_in |=> protection_active_out ==
      $past(sw_brownout_enable_in && detector_ready_in))
      else $error("software mode protection mismatch");
   a_sw_skip: assert property (@(posedge clk_in) disable iff (reset_in)
      (state == st_wake) && mode_sw && !sw_brownout_enable_in && clk_en_in
      |=> !core_hold_out)
      else $error("software mode wake waited needlessly");
   a_ready_mirror: assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in |=> brownout_ready_flag_out == $past(detector_ready_in))
      else $error("ready flag does not mirror detector");
   a_off_mode: assert property (@(posedge clk_in) disable iff (reset_in)
      brownout_mode_select_in == `BOR_MODE_OFF && clk_en_in
      |=> !protection_active_out && !brownout_reset_out)
      else $error("mode 00 protection active");
   a_bor_assert: assert property (@(posedge clk_in) disable iff (reset_in)
      next_prot && !supply_good_in && clk_en_in |=> brownout_reset_out)
      else $error("brown-out reset not asserted");

   // stall, sequencing and per-mode checks
   a_hold_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(core_hold_out))
      else $error("core hold moved while clock enable low");

   a_prot_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(protection_active_out))
      else $error("protection moved while clock enable low");

   a_bor_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(brownout_reset_out))
      else $error("brown-out reset moved while clock enable low");

   a_flag_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(brownout_ready_flag_out))
      else $error("ready flag moved while clock enable low");

   a_sleep_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(in_sleep_out))
      else $error("sleep flag moved while clock enable low");

   a_state_frozen: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !clk_en_in
      |=> $stable(state))
      else $error("state moved while clock enable low");

   a_sleep_entry: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_run && sleep_request_in && clk_en_in
      |=> in_sleep_out && core_hold_out)
      else $error("sleep request not taken");

   a_start_no_sleep: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_start && clk_en_in
      |=> !in_sleep_out)
      else $error("sleep entered straight from start");

   a_sleep_stays: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_sleep && !wake_event_in && clk_en_in
      |=> in_sleep_out)
      else $error("sleep left without wake event");

   a_ns_wake_go: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_wake && mode_ns && ready_good && clk_en_in
      |=> !core_hold_out)
      else $error("mode 10 wake not released");

   a_on_start_go: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_start && mode_on && ready_good && clk_en_in
      |=> !core_hold_out)
      else $error("always-on start not released");

   a_sw_wake_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_wake && mode_sw && sw_brownout_enable_in
      && !ready_good && clk_en_in |=> core_hold_out)
      else $error("software mode wake released early");

   a_sw_por_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_start && mode_sw && por_start && !ready_good
      && clk_en_in |=> core_hold_out)
      else $error("software mode power-on start released early");

   a_sw_not_ready: assert property (
      @(posedge clk_in) disable iff (reset_in)
      mode_sw && !detector_ready_in && clk_en_in
      |=> !protection_active_out)
      else $error("software mode protects before ready");

   a_off_ignores_sw: assert property (
      @(posedge clk_in) disable iff (reset_in)
      mode_off && sw_brownout_enable_in && clk_en_in
      |=> !protection_active_out)
      else $error("mode 00 obeyed software enable");

   a_ns_run_prot: assert property (
      @(posedge clk_in) disable iff (reset_in)
      mode_ns && next_state == st_run && clk_en_in
      |=> protection_active_out)
      else $error("mode 10 not protecting while running");

   a_on_sleep_prot: assert property (
      @(posedge clk_in) disable iff (reset_in)
      mode_on && state == st_sleep && clk_en_in
      |=> protection_active_out)
      else $error("always-on mode lost protection in sleep");

   a_bor_needs_prot: assert property (
      @(posedge clk_in) disable iff (reset_in)
      clk_en_in && !next_prot
      |=> !brownout_reset_out)
      else $error("brown-out reset without protection");

   a_bor_supply_ok: assert property (
      @(posedge clk_in) disable iff (reset_in)
      clk_en_in && supply_good_in
      |=> !brownout_reset_out)
      else $error("brown-out reset with good supply");

   a_hold_in_sleep: assert property (
      @(posedge clk_in) disable iff (reset_in)
      clk_en_in && next_state == st_sleep
      |=> core_hold_out)
      else $error("core not held in sleep");

   a_run_no_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      clk_en_in && next_state == st_run
      |=> !core_hold_out && !in_sleep_out)
      else $error("core held while running");

   a_sw_sleep_same: assert property (
      @(posedge clk_in) disable iff (reset_in)
      mode_sw && state == st_sleep && clk_en_in |=> protection_active_out
      == $past(sw_brownout_enable_in && detector_ready_in))
      else $error("software mode protection changed by sleep");

   a_por_clear: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state == st_start && next_state == st_run && clk_en_in
      |=> !por_start)
      else $error("power-on start mark not cleared");

   a_por_set: assert property (
      @(posedge clk_in) disable iff (reset_in)
      state != st_start && por_bor_start_in && clk_en_in
      |=> por_start)
      else $error("power-on start mark not set");

endmodule // brownout_reset_mode_control
`default_nettype wire

// *** rtl/bor_ctrl_params.svh ***
// constants for the brown-out mode control block
`ifndef BOR_CTRL_PARAMS_SVH
`define BOR_CTRL_PARAMS_SVH
`define BOR_MODE_OFF 2'h0
`define BOR_MODE_SW 2'h1
`define BOR_MODE_NOSLEEP 2'h2
`define BOR_MODE_ON 2'h3
`define BOR_MODE_RESET 2'h3
`endif

// *** rtl/bor_ctrl_pkg.sv ***
// types for the brown-out mode control block
`default_nettype none
package bor_ctrl_pkg;
   typedef enum logic [1:0] {
      st_start = 2'b00,
      st_run = 2'b01,
      st_sleep = 2'b10,
      st_wake = 2'b11
   } bor_state_type;
endpackage
`default_nettype wire

// *** dv/bor_detector_model.sv ***
// behavioural brown-out detector and supply monitor
`default_nettype none
module bor_detector_model (
   input wire logic ready_cmd_in,
   input wire logic good_cmd_in,
   output logic detector_ready_out,
   output logic supply_good_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // supply level is only confirmed once the detector is ready
   assign detector_ready_out = ready_cmd_in;
   assign supply_good_out = ready_cmd_in & good_cmd_in;
endmodule // bor_detector_model
`default_nettype wire

// *** dv/test_brownout_reset_mode_control.sv ***
// self-checking bench for the brown-out mode control block
`default_nettype none
module test_brownout_reset_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, swe = 1'b0, por = 1'b0;
   logic slp = 1'b0, wak = 1'b0, rdy_c = 1'b0, good_c = 1'b0;
   logic [1:0] mode = 2'h3;
   logic rdy, good, flag, prot, bor, hold, insl;
   int n_errors = 0, n_checks = 0, cyc = 0;
   bor_detector_model u_det (.ready_cmd_in(rdy_c), .good_cmd_in(good_c),
      .detector_ready_out(rdy), .supply_good_out(good));
   brownout_reset_mode_control u_dut (.clk_in(clk), .reset_in(rst),
      .clk_en_in(en), .brownout_mode_select_in(mode),
      .sw_brownout_enable_in(swe), .detector_ready_in(rdy),
      .supply_good_in(good), .por_bor_start_in(por),
      .sleep_request_in(slp), .wake_event_in(wak),
      .brownout_ready_flag_out(flag), .protection_active_out(prot),
      .brownout_reset_out(bor), .core_hold_out(hold),
      .in_sleep_out(insl));
   always #5 clk = ~clk;
   task step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string name, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   // one-cycle pulses on the sleep and wake requests
   task sleep_now();
      slp = 1'b1; step(1); slp = 1'b0; step(1);
   endtask
   task wake_now();
      wak = 1'b1; step(1); wak = 1'b0; step(2);
   endtask
   task test_done();
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      step(20); rst = 1'b0; step(2);
      chk("hold", 1'b1, hold);
      rdy_c = 1'b1; good_c = 1'b1; step(2);
      chk("hold", 1'b0, hold);
      chk("prot", 1'b1, prot);
      chk("flag", 1'b1, flag);
      sleep_now();
      chk("insl", 1'b1, insl);
      chk("prot", 1'b1, prot);
      good_c = 1'b0; step(2);
      chk("bor", 1'b1, bor);
      wake_now();
      chk("hold", 1'b0, hold);
      good_c = 1'b1; mode = 2'h2; step(2);
      sleep_now();
      chk("prot", 1'b0, prot);
      rdy_c = 1'b0; wake_now(); step(1);
      chk("hold", 1'b1, hold);
      rdy_c = 1'b1; step(3);
      chk("hold", 1'b0, hold);
      chk("prot", 1'b1, prot);
      mode = 2'h1; swe = 1'b1; step(2);
      chk("prot", 1'b1, prot);
      sleep_now();
      chk("prot", 1'b1, prot);
      swe = 1'b0; step(2);
      chk("prot", 1'b0, prot);
      rdy_c = 1'b0; wake_now();
      chk("hold", 1'b0, hold);
      swe = 1'b1; step(2);
      chk("prot", 1'b0, prot);
      chk("flag", 1'b0, flag);
      rdy_c = 1'b1; mode = 2'h0; step(2);
      chk("prot", 1'b0, prot);
      mode = 2'h3; step(2);
      en = 1'b0; mode = 2'h0; step(2);
      chk("prot", 1'b1, prot);
      en = 1'b1; step(2);
      chk("prot", 1'b0, prot);
      mode = 2'h2; step(2);
      sleep_now();
      good_c = 1'b0; step(2);
      chk("bor", 1'b0, bor);
      good_c = 1'b1; wake_now();
      mode = 2'h1; swe = 1'b0; rdy_c = 1'b0; rst = 1'b1; step(2);
      rst = 1'b0; step(2);
      chk("hold", 1'b1, hold);
      rdy_c = 1'b1; step(2);
      chk("hold", 1'b0, hold);
      test_done();
   end
endmodule // test_brownout_reset_mode_control
`default_nettype wire
